// ---- rtl/flash_word_pkg.sv ----
/*
  Shared constants for the single-word flash program sequencer: register byte
  offsets, field positions, unlock key values and timing counts.
  Assumes a 200 MHz core clock and an AXI4-Lite register bus.
*/
package flash_word_pkg;

  // ****************************************
  // register map (byte addresses)
  // ****************************************
  localparam logic [7:0] ADDR_PTR_UPPER = 8'h00;
  localparam logic [7:0] ADDR_PTR_HIGH = 8'h04;
  localparam logic [7:0] ADDR_PTR_LOW = 8'h08;
  localparam logic [7:0] ADDR_DATA_LATCH = 8'h0C;
  localparam logic [7:0] ADDR_TABLE_STORE = 8'h10;
  localparam logic [7:0] ADDR_KEY_PORT = 8'h14;
  localparam logic [7:0] ADDR_WRITE_CTRL = 8'h18;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h1C;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h20;
  localparam logic [7:0] ADDR_HOLD_WORD = 8'h24;
  localparam logic [7:0] ADDR_RESET_CAUSE = 8'h28;

  // ****************************************
  // flash_write_control fields
  // ****************************************
  localparam int CTRL_SINGLE_WORD = 5;
  localparam int CTRL_ERASE_SEL = 4;
  localparam int CTRL_ABORTED = 3;
  localparam int CTRL_WRITE_EN = 2;
  localparam int CTRL_START = 1;
  localparam logic [7:0] CTRL_IMPL_MASK = 8'h3E;

  // table store op: bit 0 post-increments the pointer
  localparam int STORE_POST_INC = 0;
  // reset cause register: bit 0 pin reset, bit 1 watchdog
  localparam int CAUSE_PIN = 0;
  localparam int CAUSE_WATCHDOG = 1;

  // irq status bits
  localparam int IRQ_DONE = 0;
  localparam int IRQ_ABORT = 1;

  localparam logic [7:0] KEY_FIRST = 8'h55;
  localparam logic [7:0] KEY_SECOND = 8'hAA;

  localparam logic [20:0] PTR_RESET = 21'h000000;
  localparam logic [7:0] BYTE_RESET = 8'h00;

  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_PERIOD_PS = 5000;
  localparam int WORD_WRITE_TIME_NS = 50000;
  localparam int WORD_WRITE_CYCLES = (WORD_WRITE_TIME_NS * 1000) / CLK_PERIOD_PS;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WRITE = 2'b01,
    ST_DONE = 2'b10
  } seq_state_t;

endpackage

// ---- rtl/flash_word_counter.sv ----
/*
  Down counter timing the internal word-write interval.
  Assumes load and clear are single-cycle strobes from the sequencer.
*/
`timescale 1ns/1ps
module flash_word_counter #(
  parameter int WIDTH = 24
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic load,
  input wire logic [WIDTH-1:0] load_value,
  input wire logic clear,
  output logic expired
);

  typedef struct packed {
    logic [WIDTH-1:0] count;
    logic running;
    logic expired;
  } counter_state_t;

  counter_state_t cur;
  counter_state_t next_cur;

  always_comb begin
    next_cur = cur;
    next_cur.expired = 1'b0;
    if (clear) begin
      next_cur.running = 1'b0;
      next_cur.count = '0;
    end else if (load) begin
      next_cur.running = 1'b1;
      next_cur.count = load_value;
    end else if (cur.running) begin
      if (cur.count <= WIDTH'(1)) begin
        next_cur.running = 1'b0;
        next_cur.expired = 1'b1;
        next_cur.count = '0;
      end else begin
        next_cur.count = cur.count - WIDTH'(1);
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end

  assign expired = cur.expired;

endmodule

// ---- rtl/flash_word_sequencer.sv ----
/*
  Single-word flash program sequencer with AXI4-Lite register slave.
  Holds the table pointer, data latch, two holding bytes, unlock detector,
  control register and the word-write timer; drives the flash macro and
  a CPU stall level. Assumes pin and watchdog reset causes arrive as
  one-cycle pulses that are not themselves the bus reset.
*/
`timescale 1ns/1ps
module flash_word_sequencer (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic external_reset_pin,
  input wire logic watchdog_timer,
  output logic cpu_stall,
  output logic flash_prog,
  output logic [20:0] flash_addr,
  output logic [15:0] flash_data,
  output logic irq
);

  localparam int CW = 24;
  localparam logic [CW-1:0] WRITE_LOAD = CW'(flash_word_pkg::WORD_WRITE_CYCLES);

  typedef struct packed {
    logic aw_held;
    logic [7:0] aw_addr;
    logic w_held;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [20:0] table_pointer;
    logic [7:0] table_data_latch;
    logic [15:0] hold;
    logic [1:0] key_stage;
    logic single_word_enable;
    logic erase_sel;
    logic aborted_program_flag;
    logic memory_write_enable;
    logic start;
    logic [1:0] irq_status;
    logic [1:0] irq_mask;
    logic [1:0] reset_cause;
    flash_word_pkg::seq_state_t state;
    logic cpu_stall;
    logic flash_prog;
    logic [20:0] flash_addr;
    logic [15:0] flash_data;
    logic irq;
    logic timer_load;
    logic aw_ready;
    logic w_ready;
    logic ar_ready;
  } seq_t;

  seq_t cur;
  seq_t next_cur;
  logic timer_expired;
  logic timer_clear;

  flash_word_counter #(.WIDTH(CW)) word_timer (
    .aclk(aclk),
    .aresetn(aresetn),
    .load(cur.timer_load),
    .load_value(WRITE_LOAD),
    .clear(timer_clear),
    .expired(timer_expired)
  );

  // ****************************************
  // sequencing and register file
  // ****************************************
  logic ext_abort;
  logic do_write;
  logic do_read;
  logic [7:0] wbyte;
  logic [7:0] ctrl_read;

  assign ext_abort = external_reset_pin | watchdog_timer;
  assign timer_clear = ext_abort;

  always_comb begin
    next_cur = cur;
    next_cur.timer_load = 1'b0;
    do_write = cur.aw_held && cur.w_held && !cur.bvalid;
    do_read = s_axi_arvalid && !cur.rvalid;
    wbyte = cur.w_strb[0] ? cur.w_data[7:0] : 8'h00;
    ctrl_read = {2'b00, cur.single_word_enable, cur.erase_sel, cur.aborted_program_flag,
      cur.memory_write_enable, cur.start, 1'b0};

    if (s_axi_awvalid && !cur.aw_held) begin
      next_cur.aw_held = 1'b1;
      next_cur.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !cur.w_held) begin
      next_cur.w_held = 1'b1;
      next_cur.w_data = s_axi_wdata;
      next_cur.w_strb = s_axi_wstrb;
    end
    if (cur.bvalid && s_axi_bready) begin
      next_cur.bvalid = 1'b0;
    end
    if (cur.rvalid && s_axi_rready) begin
      next_cur.rvalid = 1'b0;
    end

    // ---- register writes ----
    if (do_write) begin
      next_cur.aw_held = 1'b0;
      next_cur.w_held = 1'b0;
      next_cur.bvalid = 1'b1;
      next_cur.bresp = 2'b00;
      // any bus write other than the second key breaks the unlock
      next_cur.key_stage = 2'd0;
      unique case (cur.aw_addr)
        flash_word_pkg::ADDR_PTR_UPPER: if (cur.w_strb[0]) begin
          next_cur.table_pointer[20:16] = wbyte[4:0];
        end
        flash_word_pkg::ADDR_PTR_HIGH: if (cur.w_strb[0]) begin
          next_cur.table_pointer[15:8] = wbyte;
        end
        flash_word_pkg::ADDR_PTR_LOW: if (cur.w_strb[0]) begin
          next_cur.table_pointer[7:0] = wbyte;
        end
        flash_word_pkg::ADDR_DATA_LATCH: if (cur.w_strb[0]) next_cur.table_data_latch = wbyte;
        flash_word_pkg::ADDR_TABLE_STORE: begin
          // holding byte picked by pointer bit 0
          if (cur.table_pointer[0]) begin
            next_cur.hold[15:8] = cur.table_data_latch;
          end else begin
            next_cur.hold[7:0] = cur.table_data_latch;
          end
          if (cur.w_strb[0] && cur.w_data[flash_word_pkg::STORE_POST_INC]) begin
            next_cur.table_pointer = cur.table_pointer + 21'h000001;
          end
        end
        flash_word_pkg::ADDR_KEY_PORT: begin
          // nothing stored, only the detector advances
          if (cur.w_strb[0] && wbyte == flash_word_pkg::KEY_FIRST) begin
            next_cur.key_stage = 2'd1;
          end else if (cur.w_strb[0] && cur.key_stage == 2'd1 &&
              wbyte == flash_word_pkg::KEY_SECOND) begin
            next_cur.key_stage = 2'd2;
          end
        end
        flash_word_pkg::ADDR_WRITE_CTRL: if (cur.w_strb[0]) begin
          if (cur.state == flash_word_pkg::ST_IDLE) begin
            next_cur.single_word_enable = wbyte[flash_word_pkg::CTRL_SINGLE_WORD];
            next_cur.erase_sel = wbyte[flash_word_pkg::CTRL_ERASE_SEL];
            next_cur.memory_write_enable = wbyte[flash_word_pkg::CTRL_WRITE_EN];
          end
          // software may only clear the aborted flag
          if (!wbyte[flash_word_pkg::CTRL_ABORTED]) next_cur.aborted_program_flag = 1'b0;
          if (wbyte[flash_word_pkg::CTRL_START] && cur.state == flash_word_pkg::ST_IDLE &&
              cur.memory_write_enable && cur.key_stage == 2'd2 &&
              wbyte[flash_word_pkg::CTRL_WRITE_EN]) begin
            next_cur.start = 1'b1;
            next_cur.state = flash_word_pkg::ST_WRITE;
            next_cur.timer_load = 1'b1;
            next_cur.cpu_stall = 1'b1;
            next_cur.flash_prog = 1'b1;
            next_cur.flash_addr = cur.single_word_enable ? {cur.table_pointer[20:1], 1'b0}
              : {cur.table_pointer[20:6], 6'h00};
            next_cur.flash_data = cur.hold;
          end
        end
        flash_word_pkg::ADDR_IRQ_STATUS: if (cur.w_strb[0]) begin
          next_cur.irq_status = cur.irq_status & ~wbyte[1:0];
        end
        flash_word_pkg::ADDR_IRQ_MASK: if (cur.w_strb[0]) next_cur.irq_mask = wbyte[1:0];
        flash_word_pkg::ADDR_RESET_CAUSE: if (cur.w_strb[0]) begin
          next_cur.reset_cause = cur.reset_cause & ~wbyte[1:0];
        end
        flash_word_pkg::ADDR_HOLD_WORD: next_cur.bresp = 2'b00;
        default: next_cur.bresp = 2'b10;
      endcase
    end

    // ---- write cycle ----
    unique case (cur.state)
      flash_word_pkg::ST_IDLE: begin
      end
      flash_word_pkg::ST_WRITE: begin
        if (ext_abort) begin
          next_cur.aborted_program_flag = 1'b1;
          next_cur.irq_status[flash_word_pkg::IRQ_ABORT] = 1'b1;
          next_cur.state = flash_word_pkg::ST_IDLE;
          next_cur.start = 1'b0;
          next_cur.cpu_stall = 1'b0;
          next_cur.flash_prog = 1'b0;
        end else if (timer_expired) begin
          next_cur.state = flash_word_pkg::ST_DONE;
          next_cur.flash_prog = 1'b0;
        end
      end
      flash_word_pkg::ST_DONE: begin
        next_cur.state = flash_word_pkg::ST_IDLE;
        next_cur.start = 1'b0;
        next_cur.cpu_stall = 1'b0;
        next_cur.irq_status[flash_word_pkg::IRQ_DONE] = 1'b1;
      end
      default: next_cur.state = flash_word_pkg::ST_IDLE;
    endcase
    if (external_reset_pin) next_cur.reset_cause[flash_word_pkg::CAUSE_PIN] = 1'b1;
    if (watchdog_timer) next_cur.reset_cause[flash_word_pkg::CAUSE_WATCHDOG] = 1'b1;

    // ---- register reads ----
    if (do_read) begin
      next_cur.rvalid = 1'b1;
      next_cur.rresp = 2'b00;
      next_cur.rdata = 32'h00000000;
      unique case (s_axi_araddr)
        flash_word_pkg::ADDR_PTR_UPPER: next_cur.rdata[4:0] = cur.table_pointer[20:16];
        flash_word_pkg::ADDR_PTR_HIGH: next_cur.rdata[7:0] = cur.table_pointer[15:8];
        flash_word_pkg::ADDR_PTR_LOW: next_cur.rdata[7:0] = cur.table_pointer[7:0];
        flash_word_pkg::ADDR_DATA_LATCH: next_cur.rdata[7:0] = cur.table_data_latch;
        flash_word_pkg::ADDR_TABLE_STORE: next_cur.rdata[7:0] = 8'h00;
        flash_word_pkg::ADDR_KEY_PORT: next_cur.rdata[7:0] = 8'h00;
        flash_word_pkg::ADDR_WRITE_CTRL: next_cur.rdata[7:0] = ctrl_read;
        flash_word_pkg::ADDR_IRQ_STATUS: next_cur.rdata[1:0] = cur.irq_status;
        flash_word_pkg::ADDR_IRQ_MASK: next_cur.rdata[1:0] = cur.irq_mask;
        flash_word_pkg::ADDR_HOLD_WORD: next_cur.rdata[15:0] = cur.hold;
        flash_word_pkg::ADDR_RESET_CAUSE: next_cur.rdata[1:0] = cur.reset_cause;
        default: next_cur.rresp = 2'b10;
      endcase
    end

    next_cur.irq = |(next_cur.irq_status & next_cur.irq_mask);
    // readies registered so that every bus output leaves a flip-flop
    next_cur.aw_ready = !next_cur.aw_held;
    next_cur.w_ready = !next_cur.w_held;
    next_cur.ar_ready = !next_cur.rvalid;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cur <= '0;
      // slots are empty in reset, so the readies idle high
      cur.aw_ready <= 1'b1;
      cur.w_ready <= 1'b1;
      cur.ar_ready <= 1'b1;
    end else begin
      cur <= next_cur;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign s_axi_awready = cur.aw_ready;
  assign s_axi_wready = cur.w_ready;
  assign s_axi_bvalid = cur.bvalid;
  assign s_axi_bresp = cur.bresp;
  assign s_axi_arready = cur.ar_ready;
  assign s_axi_rvalid = cur.rvalid;
  assign s_axi_rdata = cur.rdata;
  assign s_axi_rresp = cur.rresp;
  assign cpu_stall = cur.cpu_stall;
  assign flash_prog = cur.flash_prog;
  assign flash_addr = cur.flash_addr;
  assign flash_data = cur.flash_data;
  assign irq = cur.irq;

endmodule

// ---- tb/flash_word_props.sv ----
/*
  Port checker for the single-word flash program sequencer.
  Assumes binding to flash_word_sequencer, one clock, sync active-low reset.
*/
`timescale 1ns/1ps
module flash_word_props (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic external_reset_pin,
  input wire logic watchdog_timer,
  input wire logic cpu_stall,
  input wire logic flash_prog,
  input wire logic [20:0] flash_addr,
  input wire logic [15:0] flash_data
);
  // ****************************************
  // programming length counter
  // ****************************************
  logic [15:0] prog_cnt;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prog_cnt <= 16'h0000;
    end else begin
      prog_cnt <= flash_prog ? prog_cnt + 16'h0001 : 16'h0000;
    end
  end
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  // an abort also ends programming, so only a clean end is timed
  sequence clean_end;
    $fell(flash_prog) && !$past(external_reset_pin) && !$past(watchdog_timer);
  endsequence
  sequence abort_hit;
    flash_prog && (external_reset_pin || watchdog_timer);
  endsequence
  stall_cover_a: assert property (flash_prog |-> cpu_stall)
    else $error("programming without cpu stall");
  prog_length_a: assert property (clean_end |->
    prog_cnt >= flash_word_pkg::WORD_WRITE_CYCLES &&
    prog_cnt <= flash_word_pkg::WORD_WRITE_CYCLES + 2)
    else $error("word write time wrong");
  stall_release_a: assert property (clean_end |-> ##[0:1] !cpu_stall)
    else $error("stall not released after write");
  abort_stop_a: assert property (abort_hit |=> !flash_prog && !cpu_stall)
    else $error("abort did not stop write");
  addr_hold_a: assert property (flash_prog && $past(flash_prog) |->
    $stable(flash_addr) && $stable(flash_data))
    else $error("flash word changed during write");
  word_align_a: assert property (flash_prog |-> !flash_addr[0])
    else $error("word address not aligned");
  write_resp_a: assert property (wr_taken |-> ##[1:2] s_axi_bvalid)
    else $error("write response missing");
  read_resp_a: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid && !s_axi_arready)
    else $error("read response missing");
endmodule

bind flash_word_sequencer flash_word_props u_props (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid), .external_reset_pin(external_reset_pin),
  .watchdog_timer(watchdog_timer), .cpu_stall(cpu_stall), .flash_prog(flash_prog),
  .flash_addr(flash_addr), .flash_data(flash_data)
);

// ---- tb/flash_word_sequencer_tb_top.sv ----
/*
  Self-checking bench: register traffic, unlock, word write, aborts, irq.
  Assumes the sequencer alone on a 200 MHz clock; all bytes in wdata[7:0].
*/
`timescale 1ns/1ps
module flash_word_sequencer_tb_top;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic pin = 1'b0, wdog = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, stall, prog, irq;
  logic [1:0] bresp, rresp;
  logic [20:0] faddr;
  logic [15:0] fdata;
  int n_fail = 0;
  int samples_checked = 0;
  int n;
  flash_word_sequencer u_dut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .external_reset_pin(pin), .watchdog_timer(wdog), .cpu_stall(stall), .flash_prog(prog),
    .flash_addr(faddr), .flash_data(fdata), .irq(irq)
  );
  initial begin
    forever #2.5 aclk = ~aclk;
  end
  // ****************************************
  // bus tasks
  // ****************************************
  task automatic stop_test;
    if (n_fail == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR at %0t: saw %h expected %h", $time, got, exp);
    end
  endtask
  // handshake state is sampled at the falling edge to stay clear of update races
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ta, tw, tb;
    logic [1:0] r;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    tb = 1'b0;
    while (!tb) begin
      @(negedge aclk);
      ta = awready;
      tw = wready;
      tb = bvalid;
      r = bresp;
      @(posedge aclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
    end
    bready <= 1'b0;
    chk(r, 2'b00);
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    logic ta, tv;
    logic [31:0] d;
    logic [1:0] r;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    tv = 1'b0;
    while (!tv) begin
      @(negedge aclk);
      ta = arready;
      tv = rvalid;
      d = rdata;
      r = rresp;
      @(posedge aclk);
      if (ta) arvalid <= 1'b0;
    end
    rready <= 1'b0;
    chk(r, er);
    if (er == 2'b00) chk(d, e);
  endtask
  task automatic attempt(input logic [7:0] pre, k1, k2, go, input logic mid);
    wr(flash_word_pkg::ADDR_WRITE_CTRL, {24'h0, pre});
    wr(flash_word_pkg::ADDR_KEY_PORT, {24'h0, k1});
    if (mid) wr(flash_word_pkg::ADDR_PTR_HIGH, 32'hA5);
    wr(flash_word_pkg::ADDR_KEY_PORT, {24'h0, k2});
    wr(flash_word_pkg::ADDR_WRITE_CTRL, {24'h0, go});
  endtask
  // ****************************************
  // tests
  // ****************************************
  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    rc(flash_word_pkg::ADDR_WRITE_CTRL, 32'h0, 2'b00);
    rc(8'h30, 32'h0, 2'b10);
    wr(flash_word_pkg::ADDR_PTR_UPPER, 32'hFF);
    rc(flash_word_pkg::ADDR_PTR_UPPER, 32'h1F, 2'b00);
    wr(flash_word_pkg::ADDR_PTR_HIGH, 32'hA5);
    rc(flash_word_pkg::ADDR_PTR_HIGH, 32'hA5, 2'b00);
    wr(flash_word_pkg::ADDR_PTR_LOW, 32'h3C);
    wr(flash_word_pkg::ADDR_DATA_LATCH, 32'h11);
    wr(flash_word_pkg::ADDR_TABLE_STORE, 32'h1);
    wr(flash_word_pkg::ADDR_DATA_LATCH, 32'h22);
    wr(flash_word_pkg::ADDR_TABLE_STORE, 32'h0);
    rc(flash_word_pkg::ADDR_HOLD_WORD, 32'h2211, 2'b00);
    rc(flash_word_pkg::ADDR_PTR_LOW, 32'h3D, 2'b00);
    wr(flash_word_pkg::ADDR_KEY_PORT, 32'h55);
    rc(flash_word_pkg::ADDR_KEY_PORT, 32'h0, 2'b00);
    wr(flash_word_pkg::ADDR_WRITE_CTRL, 32'hFF);
    rc(flash_word_pkg::ADDR_WRITE_CTRL, 32'h34, 2'b00);
    attempt(8'h20, 8'h55, 8'hAA, 8'h22, 1'b0);
    rc(flash_word_pkg::ADDR_WRITE_CTRL, 32'h20, 2'b00);
    attempt(8'h24, 8'h55, 8'hAA, 8'h26, 1'b1);
    rc(flash_word_pkg::ADDR_WRITE_CTRL, 32'h24, 2'b00);
    attempt(8'h24, 8'hAA, 8'h55, 8'h26, 1'b0);
    rc(flash_word_pkg::ADDR_WRITE_CTRL, 32'h24, 2'b00);
    chk(prog, 1'b0);
    attempt(8'h24, 8'h55, 8'hAA, 8'h26, 1'b0);
    @(negedge aclk);
    chk(prog, 1'b1);
    chk(stall, 1'b1);
    chk(faddr, 21'h1FA53C);
    chk(fdata, 16'h2211);
    rc(flash_word_pkg::ADDR_WRITE_CTRL, 32'h26, 2'b00);
    n = 0;
    while (prog === 1'b1) begin
      @(negedge aclk);
      n++;
    end
    chk(n >= flash_word_pkg::WORD_WRITE_CYCLES - 8, 1'b1);
    chk(n <= flash_word_pkg::WORD_WRITE_CYCLES + 2, 1'b1);
    repeat (2) @(negedge aclk);
    chk(stall, 1'b0);
    rc(flash_word_pkg::ADDR_WRITE_CTRL, 32'h24, 2'b00);
    wr(flash_word_pkg::ADDR_WRITE_CTRL, 32'h04);
    wr(flash_word_pkg::ADDR_WRITE_CTRL, 32'h00);
    rc(flash_word_pkg::ADDR_WRITE_CTRL, 32'h0, 2'b00);
    rc(flash_word_pkg::ADDR_IRQ_STATUS, 32'h1, 2'b00);
    chk(irq, 1'b0);
    wr(flash_word_pkg::ADDR_IRQ_MASK, 32'h1);
    rc(flash_word_pkg::ADDR_IRQ_MASK, 32'h1, 2'b00);
    chk(irq, 1'b1);
    wr(flash_word_pkg::ADDR_IRQ_STATUS, 32'h1);
    rc(flash_word_pkg::ADDR_IRQ_STATUS, 32'h0, 2'b00);
    chk(irq, 1'b0);
    for (int i = 0; i < 2; i++) begin
      attempt(8'h24, 8'h55, 8'hAA, 8'h26, 1'b0);
      repeat (50) @(posedge aclk);
      if (i == 1) pin <= 1'b1;
      else wdog <= 1'b1;
      @(posedge aclk);
      pin <= 1'b0;
      wdog <= 1'b0;
      repeat (2) @(negedge aclk);
      chk(prog, 1'b0);
      rc(flash_word_pkg::ADDR_WRITE_CTRL, 32'h2C, 2'b00);
      rc(flash_word_pkg::ADDR_HOLD_WORD, 32'h2211, 2'b00);
      rc(flash_word_pkg::ADDR_RESET_CAUSE, (i == 1) ? 32'h1 : 32'h2, 2'b00);
      wr(flash_word_pkg::ADDR_RESET_CAUSE, 32'h3);
      wr(flash_word_pkg::ADDR_WRITE_CTRL, 32'h24);
      rc(flash_word_pkg::ADDR_WRITE_CTRL, 32'h24, 2'b00);
    end
    chk(irq, 1'b0);
    wr(flash_word_pkg::ADDR_IRQ_MASK, 32'h3);
    rc(flash_word_pkg::ADDR_IRQ_STATUS, 32'h2, 2'b00);
    chk(irq, 1'b1);
    wr(flash_word_pkg::ADDR_IRQ_STATUS, 32'h2);
    rc(flash_word_pkg::ADDR_IRQ_STATUS, 32'h0, 2'b00);
    chk(irq, 1'b0);
    stop_test();
  end
  initial begin
    #200000;
    n_fail++;
    stop_test();
  end
endmodule
